// [logic/vdrs_top.sv]
`timescale 1ns/100ps
// Functional notes
// - signed 12-bit code drives linear converter
// - low gain: 125 uV step around mid
// - high gain: fourfold step around mid
// - park launched by command, powerdown, thermal
// - no park start while actuator sleep set
// - steps brake, slow, full in order
// - spindle isolation open during whole sequence
// - powerdown park holds reset output low
// - brake: both low sides on, highs off
// - slow: neg low side off, pmos sources
// - 3-bit level, 125 mV steps
// - ramp neg terminal up in 250 mV
// - sequencer timed by phase A back-emf
// - brake lasts N*2+1 periods, zero none
// - slow lasts N+1 periods, zero none
// - full lasts N*32+1 periods, zero none
// - powerdown park ends with spindle short
// - overtemperature forces park, spindle off
// - supply low drops reset, parks, resets logic
module vdrs_top #(
  parameter int DATA_W = vdrs_pkg::DATA_W
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_arst_n,
  input  wire vdrs_pkg::vdrs_wr_t i_wr,
  input  wire logic             i_park_cmd,
  input  wire logic             i_supply_low,
  input  wire logic             i_over_temp,
  input  wire logic             i_actuator_sleep,
  input  wire logic             i_spindle_phase_a,
  output logic [13:0]           o_actuator_command_voltage,
  output logic                  o_cmd_written,
  output vdrs_pkg::vdrs_bridge_t o_bridge,
  output logic [3:0]            o_neg_terminal_level,
  output logic                  o_spindle_isolation_open,
  output logic                  o_spindle_disable,
  output logic                  o_spindle_short,
  output logic                  o_power_on_reset_n,
  output logic                  o_park_busy
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  vdrs_pkg::vdrs_state_t state;
  vdrs_pkg::vdrs_state_t next_state;
  logic [DATA_W-1:0]     slow_retract_level;
  logic [DATA_W-1:0]     park_step_durations;
  logic [13:0]           dac_code;
  logic [vdrs_pkg::CNT_W-1:0] step_cnt;
  logic [vdrs_pkg::CNT_W-1:0] next_len;
  logic [3:0]            ramp_level;
  logic                  bemf_edge;
  logic                  sup_low_s;
  logic                  temp_s;
  logic                  pd_park;
  logic                  start;
  logic                  step_done;
  logic [2:0]            sup_sync;
  logic [2:0]            temp_sync;

  // count loaded for a step, one period short of its length, zero code means skip
  function automatic logic [vdrs_pkg::CNT_W-1:0] step_len(
    input vdrs_pkg::vdrs_state_t st,
    input logic [DATA_W-1:0] durs
  );
    logic [vdrs_pkg::CNT_W-1:0] n;
    n = '0;
    unique case (st)
      vdrs_pkg::VDRS_BRAKE:
        n = vdrs_pkg::CNT_W'(durs[vdrs_pkg::BRAKE_LSB +: vdrs_pkg::BRAKE_W]
            * vdrs_pkg::BRAKE_MULT);
      vdrs_pkg::VDRS_SLOW:
        n = vdrs_pkg::CNT_W'(durs[vdrs_pkg::SLOW_LSB +: vdrs_pkg::SLOW_W]
            * vdrs_pkg::SLOW_MULT);
      vdrs_pkg::VDRS_FULL:
        n = vdrs_pkg::CNT_W'(durs[vdrs_pkg::FULL_LSB +: vdrs_pkg::FULL_W]
            * vdrs_pkg::FULL_MULT);
      default:
        n = '0;
    endcase
    return n;
  endfunction

  // step after st, skipping zero-length steps
  function automatic vdrs_pkg::vdrs_state_t after(
    input vdrs_pkg::vdrs_state_t st,
    input logic [DATA_W-1:0] durs,
    input logic pd
  );
    vdrs_pkg::vdrs_state_t r;
    r = vdrs_pkg::VDRS_IDLE;
    if (st == vdrs_pkg::VDRS_IDLE &&
        step_len(vdrs_pkg::VDRS_BRAKE, durs) != '0) begin
      r = vdrs_pkg::VDRS_BRAKE;
    end else if ((st == vdrs_pkg::VDRS_IDLE || st == vdrs_pkg::VDRS_BRAKE)
                 && step_len(vdrs_pkg::VDRS_SLOW, durs) != '0) begin
      r = vdrs_pkg::VDRS_SLOW;
    end else if (st != vdrs_pkg::VDRS_FULL &&
                 step_len(vdrs_pkg::VDRS_FULL, durs) != '0) begin
      r = vdrs_pkg::VDRS_FULL;
    end else if (pd) begin
      r = vdrs_pkg::VDRS_SHORT;
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  vdrs_edge_sync u_bemf (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_pin     (i_spindle_phase_a),
    .o_rise    (bemf_edge)
  );

  // supply and thermal flags come from analog comparators
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sup_sync  <= '0;
      temp_sync <= '0;
    end else begin
      sup_sync  <= {sup_sync[1:0], i_supply_low};
      temp_sync <= {temp_sync[1:0], i_over_temp};
    end
  end

  // level taken only when the two late stages agree
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sup_low_s <= 1'b0;
      temp_s    <= 1'b0;
    end else begin
      if (sup_sync[1] == sup_sync[2]) begin
        sup_low_s <= sup_sync[2];
      end
      if (temp_sync[1] == temp_sync[2]) begin
        temp_s <= temp_sync[2];
      end
    end
  end

  // ------------------------------------------------------------
  // registers, write only; logic in reset while supply low
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slow_retract_level  <= '0;
      park_step_durations <= '0;
    end else if (i_wr.we && o_power_on_reset_n) begin
      if (i_wr.addr == vdrs_pkg::ADDR_SLOW_RETRACT_LEVEL) begin
        slow_retract_level <= i_wr.data;
      end
      if (i_wr.addr == vdrs_pkg::ADDR_PARK_STEP_DURATIONS) begin
        park_step_durations <= i_wr.data;
      end
    end
  end

  // converter code: sign-extended, scaled, offset to mid scale.
  // reset loads mid scale, the same value a written code of 0x000 gives
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dac_code      <= vdrs_pkg::DAC_MID;
      o_cmd_written <= 1'b0;
    end else if (i_wr.we && o_power_on_reset_n) begin
      if (i_wr.addr == vdrs_pkg::ADDR_CMD_LOW_GAIN) begin
        dac_code <= vdrs_pkg::DAC_MID
                  + {{2{i_wr.data[11]}}, i_wr.data};
        o_cmd_written <= 1'b1;
      end else if (i_wr.addr == vdrs_pkg::ADDR_CMD_HIGH_GAIN) begin
        dac_code <= vdrs_pkg::DAC_MID
                  + ({{2{i_wr.data[11]}}, i_wr.data}
                     << vdrs_pkg::HIGH_GAIN_SHIFT);
        o_cmd_written <= 1'b1;
      end
    end
  end

  assign o_actuator_command_voltage = dac_code;

  // ------------------------------------------------------------
  // park sequencer
  // ------------------------------------------------------------
  assign start = (state == vdrs_pkg::VDRS_IDLE) && !i_actuator_sleep
               && (i_park_cmd || sup_low_s || temp_s);
  assign step_done = bemf_edge && (step_cnt == '0);
  assign next_len  = step_len(next_state, park_step_durations);

  // next step is chosen as a step ends; the steps only move on
  // back-emf edges, so a stalled spindle freezes the sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      vdrs_pkg::VDRS_IDLE: begin
        if (start) begin
          next_state = after(state, park_step_durations,
                             sup_low_s);
        end
      end
      vdrs_pkg::VDRS_BRAKE,
      vdrs_pkg::VDRS_SLOW,
      vdrs_pkg::VDRS_FULL: begin
        if (step_done) begin
          next_state = after(state, park_step_durations, pd_park);
        end
      end
      vdrs_pkg::VDRS_SHORT: begin
        if (!sup_low_s) begin
          next_state = vdrs_pkg::VDRS_IDLE;
        end
      end
      default: next_state = vdrs_pkg::VDRS_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= vdrs_pkg::VDRS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // period counter reloaded on step entry; the extra period of
  // each step is the count down through zero
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      step_cnt <= '0;
    end else if (next_state != state) begin
      step_cnt <= next_len;
    end else if (bemf_edge && step_cnt != '0) begin
      step_cnt <= step_cnt - 1'b1;
    end
  end

  // remember a power-down launch until the sequence ends
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pd_park <= 1'b0;
    end else if (state == vdrs_pkg::VDRS_IDLE) begin
      pd_park <= start && sup_low_s;
    end else if (sup_low_s) begin
      pd_park <= 1'b1;
    end
  end

  // neg terminal level: slow uses programmed code, full ramps up.
  // idle reloads the code too, so a skipped slow step never starts
  // the ramp from a level left over by an earlier sequence
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ramp_level <= '0;
    end else if (state == vdrs_pkg::VDRS_IDLE ||
                 next_state == vdrs_pkg::VDRS_SLOW) begin
      ramp_level <= {1'b0, slow_retract_level[vdrs_pkg::LEVEL_LSB +:
                                              vdrs_pkg::LEVEL_W]};
    end else if (state == vdrs_pkg::VDRS_FULL && bemf_edge &&
                 ramp_level != vdrs_pkg::FULL_LEVEL) begin
      ramp_level <= (ramp_level > vdrs_pkg::FULL_LEVEL
                     - vdrs_pkg::RAMP_STEP) ? vdrs_pkg::FULL_LEVEL
                    : ramp_level + vdrs_pkg::RAMP_STEP;
    end
  end

  // ------------------------------------------------------------
  // power stage controls, registered
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bridge                 <= '0;
      o_neg_terminal_level     <= '0;
      o_spindle_isolation_open <= 1'b0;
      o_spindle_short          <= 1'b0;
      o_park_busy              <= 1'b0;
    end else begin
      o_bridge <= '0;
      o_neg_terminal_level <= '0;
      unique case (next_state)
        vdrs_pkg::VDRS_BRAKE: begin
          o_bridge.n_minus_on <= 1'b1;
          o_bridge.n_plus_on  <= 1'b1;
        end
        vdrs_pkg::VDRS_SLOW: begin
          o_bridge.n_plus_on       <= 1'b1;
          o_bridge.retract_pmos_on <= 1'b1;
          o_neg_terminal_level     <= {1'b0, slow_retract_level[
            vdrs_pkg::LEVEL_LSB +: vdrs_pkg::LEVEL_W]};
        end
        vdrs_pkg::VDRS_FULL: begin
          o_bridge.n_plus_on       <= 1'b1;
          o_bridge.retract_pmos_on <= 1'b1;
          o_neg_terminal_level     <= ramp_level;
        end
        default: ;
      endcase
      o_spindle_isolation_open <= next_state != vdrs_pkg::VDRS_IDLE;
      o_spindle_short <= next_state == vdrs_pkg::VDRS_SHORT;
      o_park_busy <= next_state != vdrs_pkg::VDRS_IDLE;
    end
  end

  // supply loss drops the reset output at once; a power-down park
  // keeps it low until the sequence is over
  assign o_power_on_reset_n = !sup_low_s &&
                              !(pd_park &&
                                state != vdrs_pkg::VDRS_IDLE);
  assign o_spindle_disable = temp_s;

endmodule

// [logic/vdrs_pkg.sv]
package vdrs_pkg;

  // ---------------------------------------------------------------
  // register map (serial register numbers)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_SLOW_RETRACT_LEVEL = 4'h2;
  localparam logic [3:0] ADDR_PARK_STEP_DURATIONS = 4'h3;
  localparam logic [3:0] ADDR_CMD_LOW_GAIN = 4'h7;
  localparam logic [3:0] ADDR_CMD_HIGH_GAIN = 4'h8;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 3;
  localparam int BRAKE_LSB = 0;
  localparam int BRAKE_W = 3;
  localparam int SLOW_LSB = 3;
  localparam int SLOW_W = 6;
  localparam int FULL_LSB = 9;
  localparam int FULL_W = 3;
  localparam int DATA_W = 12;

  // step length multipliers, in back-emf periods
  localparam int BRAKE_MULT = 2;
  localparam int SLOW_MULT = 1;
  localparam int FULL_MULT = 32;
  localparam int CNT_W = 9;

  // neg terminal ramp: 250 mV is two 125 mV level codes
  localparam logic [3:0] RAMP_STEP = 4'h2;
  localparam logic [3:0] FULL_LEVEL = 4'hf;

  // converter: 0x000 maps to mid scale, high gain uses 4x step
  localparam logic [13:0] DAC_MID = 14'h2000;
  localparam int HIGH_GAIN_SHIFT = 2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    VDRS_IDLE  = 5'b00001,
    VDRS_BRAKE = 5'b00010,
    VDRS_SLOW  = 5'b00100,
    VDRS_FULL  = 5'b01000,
    VDRS_SHORT = 5'b10000
  } vdrs_state_t;

  typedef struct packed {
    logic n_minus_on;
    logic n_plus_on;
    logic p_minus_on;
    logic p_plus_on;
    logic retract_pmos_on;
  } vdrs_bridge_t;

  typedef struct packed {
    logic       we;
    logic [3:0] addr;
    logic [11:0] data;
  } vdrs_wr_t;

endpackage

// [logic/vdrs_edge_sync.sv]
`timescale 1ns/100ps
// three-stage pin synchroniser; a rising edge counts once stages two and three
// agree on a new value
module vdrs_edge_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  input  wire logic i_pin,
  output logic      o_rise
);

  logic s1;
  logic s2;
  logic s3;
  logic held;

  // ------------------------------------------------------------
  // synchroniser chain
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // accepted level moves only when the last two stages agree
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      held <= 1'b0;
    end else if (s2 == s3) begin
      held <= s3;
    end
  end

  assign o_rise = (s2 == s3) && s3 && !held;

endmodule

// [testbench/vdrs_chk.sv]
`timescale 1ns/100ps
// ---------------------------------------------------------------
// port checker for the converter and the park sequencer
// ---------------------------------------------------------------
module vdrs_chk #(
  parameter int DATA_W = vdrs_pkg::DATA_W
) (
  input wire logic                   i_sys_clk,
  input wire logic                   i_arst_n,
  input wire vdrs_pkg::vdrs_wr_t     i_wr,
  input wire logic                   i_park_cmd,
  input wire logic                   i_supply_low,
  input wire logic                   i_actuator_sleep,
  input wire logic [13:0]            o_actuator_command_voltage,
  input wire vdrs_pkg::vdrs_bridge_t o_bridge,
  input wire logic [3:0]             o_neg_terminal_level,
  input wire logic                   o_spindle_isolation_open,
  input wire logic                   o_spindle_short,
  input wire logic                   o_power_on_reset_n,
  input wire logic                   o_park_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  // writes only count while the reset output is released
  logic wr_ok;
  assign wr_ok = i_wr.we && o_power_on_reset_n;

  property p_dac_low;
    wr_ok && i_wr.addr == vdrs_pkg::ADDR_CMD_LOW_GAIN |=>
      o_actuator_command_voltage == vdrs_pkg::DAC_MID +
      {{2{$past(i_wr.data[DATA_W-1])}}, $past(i_wr.data)};
  endproperty
  a_dac_low: assert property (p_dac_low)
    else $error("low gain output wrong");

  property p_dac_high;
    wr_ok && i_wr.addr == vdrs_pkg::ADDR_CMD_HIGH_GAIN |=>
      o_actuator_command_voltage ==
      vdrs_pkg::DAC_MID + {$past(i_wr.data), 2'b00};
  endproperty
  a_dac_high: assert property (p_dac_high)
    else $error("high gain output wrong");

  property p_start;
    i_park_cmd && !o_park_busy && !i_actuator_sleep &&
      o_power_on_reset_n && !o_spindle_short |-> ##[1:2] o_park_busy;
  endproperty
  a_start: assert property (p_start)
    else $error("park request not taken");

  property p_sleep;
    $rose(o_park_busy) |-> !$past(i_actuator_sleep);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("park began while asleep");

  property p_iso;
    o_park_busy |-> o_spindle_isolation_open;
  endproperty
  a_iso: assert property (p_iso)
    else $error("isolation closed in sequence");

  property p_por_hold;
    o_park_busy && !o_power_on_reset_n |=>
      !o_park_busy || !o_power_on_reset_n;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("reset output released early");

  property p_brake;
    o_bridge.n_minus_on && o_bridge.n_plus_on |->
      !o_bridge.p_minus_on && !o_bridge.p_plus_on &&
      !o_bridge.retract_pmos_on;
  endproperty
  a_brake: assert property (p_brake)
    else $error("high side on during brake");

  property p_slow;
    o_bridge.retract_pmos_on |-> !o_bridge.n_minus_on;
  endproperty
  a_slow: assert property (p_slow)
    else $error("neg low side on while sourcing");

  // the ramp only climbs, two level codes at a time, capped at full
  property p_ramp;
    $past(o_bridge.retract_pmos_on) && o_bridge.retract_pmos_on &&
      $changed(o_neg_terminal_level) |->
      o_neg_terminal_level == $past(o_neg_terminal_level) + 4'h2 ||
      o_neg_terminal_level == vdrs_pkg::FULL_LEVEL;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("neg terminal ramp step wrong");

  property p_short;
    $rose(o_spindle_short) |-> !o_power_on_reset_n;
  endproperty
  a_short: assert property (p_short)
    else $error("spindle short outside power down");

  property p_por_low;
    $rose(i_supply_low) |-> ##[1:6] !o_power_on_reset_n;
  endproperty
  a_por_low: assert property (p_por_low)
    else $error("reset output not dropped");

  c_park: cover property ($rose(o_park_busy));
  c_short: cover property ($rose(o_spindle_short));
  c_ramp: cover property (o_neg_terminal_level == vdrs_pkg::FULL_LEVEL);
endmodule

bind vdrs_top vdrs_chk #(.DATA_W(DATA_W)) u_chk (
  .i_sys_clk, .i_arst_n, .i_wr, .i_park_cmd, .i_supply_low,
  .i_actuator_sleep, .o_actuator_command_voltage, .o_bridge,
  .o_neg_terminal_level, .o_spindle_isolation_open, .o_spindle_short,
  .o_power_on_reset_n, .o_park_busy
);

// [testbench/vdrs_spindle_model.sv]
`timescale 1ns/100ps
// ---------------------------------------------------------------
// spindle back-emf seen on phase a
// ---------------------------------------------------------------
// half period is not a multiple of the clock, so rising and falling edges sit half a clock apart in phase
module vdrs_spindle_model #(
  parameter int HALF_NS = 170
) (
  input  wire logic i_spin,
  output logic      o_phase_a
);
  // phase a rests low while the spindle is not turning
  initial begin
    o_phase_a = 1'b0;
    forever begin
      wait (i_spin);
      #HALF_NS o_phase_a = 1'b1;
      #HALF_NS o_phase_a = 1'b0;
    end
  end
endmodule

// [testbench/tb_vdrs_top.sv]
`timescale 1ns/100ps
module tb_vdrs_top;
  // ---------------------------------------------------------------
  // hook-up
  // ---------------------------------------------------------------
  logic                   i_sys_clk = 1'b0;
  logic                   i_arst_n = 1'b0;
  vdrs_pkg::vdrs_wr_t     i_wr = '0;
  logic                   i_park_cmd = 1'b0;
  logic                   i_supply_low = 1'b0;
  logic                   i_over_temp = 1'b0;
  logic                   i_actuator_sleep = 1'b0;
  logic                   i_spindle_phase_a;
  logic [13:0]            o_actuator_command_voltage;
  logic                   o_cmd_written;
  vdrs_pkg::vdrs_bridge_t o_bridge;
  logic [3:0]             o_neg_terminal_level;
  logic                   o_spindle_isolation_open;
  logic                   o_spindle_disable;
  logic                   o_spindle_short;
  logic                   o_power_on_reset_n;
  logic                   o_park_busy;
  logic                   spin = 1'b0;
  int                     err_count = 0;
  int                     checks = 0;
  int                     n_brk;
  int                     n_ret;
  logic [3:0]             lvl_max;
  logic                   saw_short;
  logic                   saw_dis;
  logic                   order_bad;

  always #10 i_sys_clk = ~i_sys_clk;

  vdrs_top u_dut (
    .i_sys_clk, .i_arst_n, .i_wr, .i_park_cmd, .i_supply_low,
    .i_over_temp, .i_actuator_sleep, .i_spindle_phase_a,
    .o_actuator_command_voltage, .o_cmd_written, .o_bridge,
    .o_neg_terminal_level, .o_spindle_isolation_open,
    .o_spindle_disable, .o_spindle_short, .o_power_on_reset_n,
    .o_park_busy
  );
  vdrs_spindle_model u_spin (
    .i_spin    (spin),
    .o_phase_a (i_spindle_phase_a)
  );

  // back-emf pulses counted per step; a brake pulse after retract is bad
  always @(posedge i_spindle_phase_a) begin
    if (o_bridge.n_minus_on && o_bridge.n_plus_on) begin
      n_brk++;
      if (n_ret > 0) order_bad = 1'b1;
    end
    if (o_bridge.retract_pmos_on) n_ret++;
  end
  // side effects of a park, sampled on the falling edge, clear of the
  // edge that launches them
  always @(negedge i_sys_clk) begin
    if (o_spindle_short) saw_short = 1'b1;
    if (o_spindle_disable) saw_dis = 1'b1;
    if (o_bridge.retract_pmos_on && o_neg_terminal_level > lvl_max)
      lvl_max = o_neg_terminal_level;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    i_wr = '{we: 1'b1, addr: a, data: d};
    tick(1);
    i_wr.we = 1'b0;
    // idle edge so a following write never re-raises we in this step
    tick(1);
  endtask

  // bounded wait; a power-down park may end in the short state
  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (o_park_busy !== v && !(!v && o_spindle_short) && k < 9000) begin
      tick(1);
      k++;
    end
    chk(k < 9000, 1'b1);
  endtask

  // program steps, fire a trigger, turn the spindle until done
  task automatic park(input int trig, input logic [11:0] durs,
                      input bit rel);
    n_brk = 0;
    n_ret = 0;
    lvl_max = 4'h0;
    saw_short = 1'b0;
    saw_dis = 1'b0;
    order_bad = 1'b0;
    wr(vdrs_pkg::ADDR_PARK_STEP_DURATIONS, durs);
    case (trig)
      0: i_park_cmd = 1'b1;
      1: i_supply_low = 1'b1;
      default: i_over_temp = 1'b1;
    endcase
    wait_busy(1'b1);
    i_park_cmd = 1'b0;
    i_over_temp = 1'b0;
    spin = 1'b1;
    if (rel) begin
      i_supply_low = 1'b0;
      tick(8);
      chk(o_power_on_reset_n, 1'b0);
    end
    wait_busy(1'b0);
    spin = 1'b0;
    tick(20);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk(o_actuator_command_voltage, 14'h2000);
    chk(o_cmd_written, 1'b0);
    chk(o_power_on_reset_n, 1'b1);
    chk(o_park_busy, 1'b0);
  endtask

  task automatic t_dac();
    logic [11:0] c [4] = '{12'h7ff, 12'h000, 12'hfff, 12'h800};
    foreach (c[i]) begin
      wr(vdrs_pkg::ADDR_CMD_LOW_GAIN, c[i]);
      chk(o_actuator_command_voltage, 14'h2000 + {{2{c[i][11]}}, c[i]});
      chk(o_cmd_written, 1'b1);
      wr(vdrs_pkg::ADDR_CMD_HIGH_GAIN, c[i]);
      chk(o_actuator_command_voltage, 14'h2000 + {c[i], 2'b00});
    end
    wr(4'h5, 12'h123);
    chk(o_actuator_command_voltage, 14'h0000);
  endtask

  task automatic t_sleep();
    i_actuator_sleep = 1'b1;
    i_park_cmd = 1'b1;
    tick(12);
    chk(o_park_busy, 1'b0);
    chk(o_spindle_isolation_open, 1'b0);
    i_park_cmd = 1'b0;
    i_actuator_sleep = 1'b0;
    tick(2);
  endtask

  task automatic t_brake();
    park(0, 12'h007, 1'b0);
    chk(n_brk, 15);
    chk(n_ret, 0);
  endtask

  task automatic t_slow();
    wr(vdrs_pkg::ADDR_SLOW_RETRACT_LEVEL, 12'h003);
    park(0, 12'h1f8, 1'b0);
    chk(n_brk, 0);
    chk(n_ret, 64);
    chk(lvl_max, 4'h3);
  endtask

  task automatic t_pdown();
    wr(vdrs_pkg::ADDR_SLOW_RETRACT_LEVEL, 12'h005);
    park(1, 12'h209, 1'b0);
    chk(n_brk, 3);
    chk(n_ret, 35);
    chk(order_bad, 1'b0);
    chk(lvl_max, 4'hf);
    chk(saw_short, 1'b1);
    chk(o_power_on_reset_n, 1'b0);
    i_supply_low = 1'b0;
    tick(10);
    chk(o_spindle_short, 1'b0);
    chk(o_power_on_reset_n, 1'b1);
  endtask

  task automatic t_temp();
    park(2, 12'he00, 1'b0);
    chk(n_brk, 0);
    chk(n_ret, 225);
    chk(lvl_max, 4'hf);
    chk(saw_dis, 1'b1);
    chk(o_spindle_disable, 1'b0);
  endtask

  task automatic t_release();
    park(1, 12'h002, 1'b1);
    chk(n_brk, 5);
    chk(o_power_on_reset_n, 1'b1);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a hung sequencer would otherwise sit out every 9000-tick bounded wait
  initial begin
    #400000;
    err_count++;
    give_verdict();
  end

  initial begin
    tick(2);
    i_arst_n = 1'b1;
    tick(1);
    t_reset();
    t_dac();
    t_sleep();
    t_brake();
    t_slow();
    t_pdown();
    t_temp();
    t_release();
    give_verdict();
  end
endmodule
